// File: core/pccs_prescaler.sv
// Power-of-two prescaler producing a one-cycle tick of the bus clock
`default_nettype none

module pccs_prescaler #(
  parameter int CODE_WIDTH  = 3,
  parameter int COUNT_WIDTH = 7
) (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  arst_n_in,
  // Divider code
  input  wire logic [CODE_WIDTH-1:0] divider_code_in,
  // Divided clock as an enable pulse
  output logic                       tick_out
);

  generate
    if (COUNT_WIDTH != (2 ** CODE_WIDTH) - 1) begin : g_bad_width
      $error("pccs_prescaler: COUNT_WIDTH must be 2**CODE_WIDTH-1");
    end
  endgenerate

  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH-1:0] tick_mask;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // Low n bits of a free-running count all ones: once every 2**n cycles
  always_comb begin
    tick_mask = COUNT_WIDTH'((1 << divider_code_in) - 1);
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= ((count & tick_mask) == tick_mask);
    end
  end

  // Three cycles: the tick flop is still at its reset value one edge after release
  a_div_one_steady : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (divider_code_in == '0) [*3] |-> tick_out)
    else $error("Divide by one does not tick every cycle");

  // A tick seen with code one in force for the two cycles that produced it
  sequence s_code_one_tick;
    (divider_code_in == CODE_WIDTH'(1)) ##1 (tick_out && divider_code_in == CODE_WIDTH'(1));
  endsequence

  a_div_two_gap : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    s_code_one_tick |=> !tick_out ##1 (tick_out || $past(divider_code_in) != CODE_WIDTH'(1)))
    else $error("Divide by two tick spacing wrong");

endmodule

`default_nettype wire

// File: core/pccs_top.sv
// PWM channel clock source select with prescalers and Avalon-MM registers
`default_nettype none

module pccs_top #(
  parameter int NUM_CHANNELS = 8,
  parameter int ADDR_WIDTH   = 8
) (
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    arst_n_in,
  // Avalon-MM slave
  input  wire logic [ADDR_WIDTH-1:0]   avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [31:0]             avs_readdata_out,
  output logic                         avs_waitrequest_out,
  // Scaled clocks from the scale dividers, one-cycle pulses
  input  wire logic                    scaled_clock_a_in,
  input  wire logic                    scaled_clock_b_in,
  // Prescaled base clocks, for the scale dividers
  output logic                         clock_a_tick_out,
  output logic                         clock_b_tick_out,
  // Per-channel counter clock enables
  output logic      [NUM_CHANNELS-1:0] channel_tick_out
);

  localparam int CW = pccs_pkg::DIVIDER_CODE_WIDTH;

  generate
    if (NUM_CHANNELS != 8) begin : g_bad_channels
      $error("pccs_top: the select map serves exactly eight channels");
    end
    if (ADDR_WIDTH < 8) begin : g_bad_addr
      $error("pccs_top: ADDR_WIDTH must cover the register map");
    end
  endgenerate

  // Registers
  logic [7:0] channel_clock_source_select;
  logic [7:0] base_clock_prescale_select;
  logic [7:0] unit_control_register;

  logic [CW-1:0] clock_a_divider_code;
  logic [CW-1:0] clock_b_divider_code;
  logic [3:0]    pair_join;

  assign clock_a_divider_code = base_clock_prescale_select[pccs_pkg::CLOCK_A_CODE_LSB +: CW];
  assign clock_b_divider_code = base_clock_prescale_select[pccs_pkg::CLOCK_B_CODE_LSB +: CW];
  assign pair_join            = unit_control_register[pccs_pkg::PAIR_JOIN_LSB +: 4];

  // ---------------------------------------------------------------
  // Bus slave: every access waits exactly one cycle
  // ---------------------------------------------------------------
  logic       bus_request;
  logic       bus_ack;
  logic       bus_accept;
  logic       write_accept;
  logic [5:0] bus_index;

  assign bus_request         = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_request & ~bus_ack;
  assign bus_accept          = bus_request & bus_ack;
  assign write_accept        = avs_write_in & bus_ack & avs_byteenable_in[0];
  assign bus_index           = avs_address_in[7:2];

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_request & ~bus_ack;
    end
  end

  function automatic logic [7:0] read_mux(input logic [5:0] index,
                                          input logic [7:0] src,
                                          input logic [7:0] pre,
                                          input logic [7:0] ctl);
    read_mux = 8'h00;
    if (index == pccs_pkg::CLOCK_SOURCE_INDEX) begin
      read_mux = src;
    end else if (index == pccs_pkg::PRESCALE_INDEX) begin
      read_mux = pre;
    end else if (index == pccs_pkg::UNIT_CONTROL_INDEX) begin
      read_mux = ctl;
    end
  endfunction

  // Read data captured in the wait cycle, stands at the accepting edge
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !bus_ack) begin
      avs_readdata_out <= {24'h00_0000, read_mux(bus_index, channel_clock_source_select,
                                                 base_clock_prescale_select, unit_control_register)};
    end
  end

  // Select changes take effect at once; a running channel may see one odd pulse
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      channel_clock_source_select <= pccs_pkg::CLOCK_SOURCE_RESET;
    end else if (write_accept && bus_index == pccs_pkg::CLOCK_SOURCE_INDEX) begin
      channel_clock_source_select <= avs_writedata_in[7:0];
    end
  end

  // Reserved bits are never stored, so they read back as zero
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      base_clock_prescale_select <= pccs_pkg::PRESCALE_RESET;
    end else if (write_accept && bus_index == pccs_pkg::PRESCALE_INDEX) begin
      base_clock_prescale_select <= avs_writedata_in[7:0] & pccs_pkg::PRESCALE_WRITE_MASK;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      unit_control_register <= pccs_pkg::UNIT_CONTROL_RESET;
    end else if (write_accept && bus_index == pccs_pkg::UNIT_CONTROL_INDEX) begin
      unit_control_register <= avs_writedata_in[7:0] & pccs_pkg::UNIT_CONTROL_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Prescalers for clock A and clock B
  // ---------------------------------------------------------------
  pccs_prescaler #(
    .CODE_WIDTH  (CW),
    .COUNT_WIDTH ((2 ** CW) - 1)
  ) u_prescaler_a (
    .clock_in        (clock_in),
    .arst_n_in       (arst_n_in),
    .divider_code_in (clock_a_divider_code),
    .tick_out        (clock_a_tick_out)
  );

  pccs_prescaler #(
    .CODE_WIDTH  (CW),
    .COUNT_WIDTH ((2 ** CW) - 1)
  ) u_prescaler_b (
    .clock_in        (clock_in),
    .arst_n_in       (arst_n_in),
    .divider_code_in (clock_b_divider_code),
    .tick_out        (clock_b_tick_out)
  );

  // ---------------------------------------------------------------
  // Channel clock routing
  // ---------------------------------------------------------------
  logic [NUM_CHANNELS-1:0] channel_source_bit;
  logic [NUM_CHANNELS-1:0] next_channel_tick;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
      // A joined pair runs from the odd channel's select
      if (ch % 2 == 0) begin : g_even
        assign channel_source_bit[ch] = pair_join[ch / 2] ? channel_clock_source_select[ch + 1]
                                                          : channel_clock_source_select[ch];
      end else begin : g_odd
        assign channel_source_bit[ch] = channel_clock_source_select[ch];
      end
      if (pccs_pkg::CLOCK_A_CHANNELS[ch]) begin : g_group_a
        assign next_channel_tick[ch] = channel_source_bit[ch] ? scaled_clock_a_in
                                                              : clock_a_tick_out;
      end else begin : g_group_b
        assign next_channel_tick[ch] = channel_source_bit[ch] ? scaled_clock_b_in
                                                              : clock_b_tick_out;
      end
    end
  endgenerate

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      channel_tick_out <= '0;
    end else begin
      channel_tick_out <= next_channel_tick;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_new_request;
    bus_request && !bus_ack;
  endsequence

  sequence s_held_request;
    bus_request && $stable(avs_address_in) && $stable(avs_read_in);
  endsequence

  a_bus_one_wait : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    s_new_request ##1 s_held_request |-> !avs_waitrequest_out)
    else $error("Bus access did not complete after one wait cycle");

  a_source_write_lands : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    write_accept && bus_index == pccs_pkg::CLOCK_SOURCE_INDEX
    |=> channel_clock_source_select == $past(avs_writedata_in[7:0]))
    else $error("Clock source write not stored");

  a_prescale_split : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    write_accept && bus_index == pccs_pkg::PRESCALE_INDEX
    |=> clock_a_divider_code == $past(avs_writedata_in[2:0])
        && clock_b_divider_code == $past(avs_writedata_in[6:4]))
    else $error("Prescale fields not taken from their own bits");

  a_reserved_zero : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (base_clock_prescale_select & ~pccs_pkg::PRESCALE_WRITE_MASK) == 8'h00)
    else $error("Reserved prescale bits not zero");

  a_chan_a_route : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    ##1 channel_tick_out[1] == $past(channel_clock_source_select[1] ? scaled_clock_a_in : clock_a_tick_out))
    else $error("Channel 1 clock routing wrong");

  a_chan_b_route : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    ##1 channel_tick_out[6] == $past((channel_clock_source_select[6] && !pair_join[3])
                                     || (channel_clock_source_select[7] && pair_join[3])
                                     ? scaled_clock_b_in : clock_b_tick_out))
    else $error("Channel 6 clock routing wrong");

  a_join_ignores_even : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    pair_join[0] |=> channel_tick_out[0] == channel_tick_out[1])
    else $error("Joined pair does not follow the odd select");

  a_even_own_select : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !pair_join[1] && channel_clock_source_select[2] |=> channel_tick_out[2] == $past(scaled_clock_b_in))
    else $error("Unjoined even channel ignores its select");

  a_single_pulse : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (clock_a_divider_code == 3'h1 && !channel_clock_source_select[5]) [*4]
    |-> !(channel_tick_out[5] && $past(channel_tick_out[5])))
    else $error("Channel tick lasted more than one cycle");

  a_b_reads_code : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    clock_b_divider_code == 3'h0 [*3] |-> clock_b_tick_out)
    else $error("Clock B ignores its code");

  // Unmapped words answer with zero at the accepting edge
  a_unmapped_zero : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    bus_accept && avs_read_in && bus_index != pccs_pkg::CLOCK_SOURCE_INDEX
    && bus_index != pccs_pkg::PRESCALE_INDEX && bus_index != pccs_pkg::UNIT_CONTROL_INDEX
    |-> avs_readdata_out == 32'h0000_0000)
    else $error("Unmapped read returned nonzero data");

  // Lane 0 disabled: the accepted write leaves every register alone
  a_write_refused : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    bus_accept && avs_write_in && !avs_byteenable_in[0]
    |=> $stable(channel_clock_source_select) && $stable(base_clock_prescale_select)
        && $stable(unit_control_register))
    else $error("Write without lane 0 changed a register");

  a_unit_ctl_low_zero : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (unit_control_register & ~pccs_pkg::UNIT_CONTROL_MASK) == 8'h00)
    else $error("Unit control low bits not zero");

  a_join_b_pair : assert property (@(posedge clock_in) disable iff (!arst_n_in)
    pair_join[1] |=> channel_tick_out[2] == channel_tick_out[3])
    else $error("Joined B pair does not follow the odd select");

endmodule

`default_nettype wire

// File: pkg/pccs_pkg.sv
// Constants shared by the PWM channel clock select block
// What this block does
// - Channels 0,1,4,5 pick clock A or scaled A
// - Channels 2,3,6,7 pick clock B or scaled B
// - Select bit n: 0 unscaled, 1 scaled
// - Joined pair ignores its even channel's select
// - Select change may glitch one pulse, accepted
// - Clock A and B prescale held separately
// - Three-bit B code sets clock B rate
// - Prescale change may glitch one pulse, accepted
// - Code n divides bus clock by 2**n
// - Three-bit A code sets clock A rate
`default_nettype none

package pccs_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] CLOCK_SOURCE_INDEX   = 6'h02;
  localparam logic [5:0] PRESCALE_INDEX       = 6'h03;
  localparam logic [5:0] UNIT_CONTROL_INDEX   = 6'h05;

  // Reset values
  localparam logic [7:0] CLOCK_SOURCE_RESET   = 8'h00;
  localparam logic [7:0] PRESCALE_RESET       = 8'h00;
  localparam logic [7:0] UNIT_CONTROL_RESET   = 8'h00;

  // Prescale register fields
  localparam int         DIVIDER_CODE_WIDTH   = 3;
  localparam int         CLOCK_A_CODE_LSB     = 0;
  localparam int         CLOCK_B_CODE_LSB     = 4;
  localparam logic [7:0] PRESCALE_WRITE_MASK  = 8'h77;

  // Unit control: pair join bits, pair p at bit PAIR_JOIN_LSB + p
  localparam int         PAIR_JOIN_LSB        = 4;
  localparam logic [7:0] UNIT_CONTROL_MASK    = 8'hf0;

  // Channels served by clock A (bit set) versus clock B
  localparam logic [7:0] CLOCK_A_CHANNELS     = 8'h33;

  function automatic logic [7:0] reg_byte_address(input logic [5:0] index);
    reg_byte_address = {index, 2'b00};
  endfunction

endpackage

`default_nettype wire

// File: testbench/pccs_top_tb.sv
// Self-checking testbench for the PWM channel clock select block
`default_nettype none

module pccs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock_in;
  logic        arst_n_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        scaled_clock_a_in;
  logic        scaled_clock_b_in;
  logic        clock_a_tick_out;
  logic        clock_b_tick_out;
  logic [7:0]  channel_tick_out;
  int          fails;
  int          compares;
  logic [31:0] rd;
  int          ca;
  int          cb;
  // Register rows: address, write data, expected read back
  logic [23:0] reg_rows [5] = '{24'h08a5a5, 24'h0cff77, 24'h14fff0, 24'h10ff00, 24'h0c3535};
  // Routing rows: source select, unit control, scaled A, scaled B
  logic [17:0] route_rows [7] = '{{8'h00, 8'h00, 2'b00}, {8'hff, 8'h00, 2'b10}, {8'hff, 8'h00, 2'b01},
                                  {8'h55, 8'h00, 2'b00}, {8'haa, 8'hf0, 2'b00}, {8'h55, 8'hf0, 2'b00},
                                  {8'h0f, 8'h30, 2'b00}};

  pccs_top dut (
    .clock_in            (clock_in),
    .arst_n_in           (arst_n_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .scaled_clock_a_in   (scaled_clock_a_in),
    .scaled_clock_b_in   (scaled_clock_b_in),
    .clock_a_tick_out    (clock_a_tick_out),
    .clock_b_tick_out    (clock_b_tick_out),
    .channel_tick_out    (channel_tick_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus access; holds the request until waitrequest is seen low
  task automatic bus_access(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge clock_in);
    avs_write_in      <= wr;
    avs_read_in       <= ~wr;
    avs_address_in    <= a;
    avs_writedata_in  <= {24'h000000, d};
    avs_byteenable_in <= be;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      finish_test();
    end
    rd = avs_readdata_out;
    check(n, 2);
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic apply_reset();
    arst_n_in <= 1'b0;
    repeat (20) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
  endtask

  function automatic logic [7:0] route(input logic [7:0] src, input logic [7:0] ctl, input logic sa, input logic sb);
    logic [7:0] r;
    logic       s;
    for (int n = 0; n < 8; n++) begin
      s = (n % 2 == 0 && ctl[4 + n / 2]) ? src[n + 1] : src[n];
      r[n] = s ? (8'h33 >> n) & 1 ? sa : sb : 1'b1;
    end
    return r;
  endfunction

  initial begin
    fails = 0;
    compares = 0;
    arst_n_in = 1'b0;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'hf;
    scaled_clock_a_in = 1'b0;
    scaled_clock_b_in = 1'b0;
    apply_reset();
    foreach (reg_rows[i]) begin
      bus_access(1'b1, reg_rows[i][23:16], reg_rows[i][15:8], 4'hf);
      bus_access(1'b0, reg_rows[i][23:16], 8'h00, 4'hf);
      check(rd, {24'h000000, reg_rows[i][7:0]});
    end
    bus_access(1'b1, 8'h0c, 8'h00, 4'hf);
    foreach (route_rows[i]) begin
      bus_access(1'b1, 8'h08, route_rows[i][17:10], 4'hf);
      bus_access(1'b1, 8'h14, route_rows[i][9:2], 4'hf);
      scaled_clock_a_in <= route_rows[i][1];
      scaled_clock_b_in <= route_rows[i][0];
      repeat (3) @(posedge clock_in);
      check(channel_tick_out, route(route_rows[i][17:10], route_rows[i][9:2], route_rows[i][1], route_rows[i][0]));
    end
    // Awkward: a lone scaled pulse reaches channel 0 one cycle later
    bus_access(1'b1, 8'h14, 8'h00, 4'hf);
    bus_access(1'b1, 8'h08, 8'h01, 4'hf);
    scaled_clock_a_in <= 1'b0;
    scaled_clock_b_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    scaled_clock_a_in <= 1'b1;
    @(posedge clock_in);
    scaled_clock_a_in <= 1'b0;
    @(posedge clock_in);
    check(channel_tick_out, 8'hff);
    @(posedge clock_in);
    check(channel_tick_out, 8'hfe);
    // Write with lane 0 disabled is ignored
    bus_access(1'b1, 8'h08, 8'h3c, 4'he);
    bus_access(1'b0, 8'h08, 8'h00, 4'hf);
    check(rd, 32'h00000001);
    // Every divider code on A, the mirrored code on B
    for (int n = 0; n < 8; n++) begin
      bus_access(1'b1, 8'h0c, {1'b0, 3'(7 - n), 1'b0, 3'(n)}, 4'hf);
      repeat (300) @(posedge clock_in);
      ca = 0;
      cb = 0;
      repeat (256) begin
        @(posedge clock_in);
        if (clock_a_tick_out === 1'b1) ca++;
        if (clock_b_tick_out === 1'b1) cb++;
      end
      check(ca, 256 >> n);
      check(cb, 256 >> (7 - n));
    end
    // Second reset in mid-run clears every register
    bus_access(1'b1, 8'h14, 8'hf0, 4'hf);
    apply_reset();
    bus_access(1'b0, 8'h08, 8'h00, 4'hf);
    check(rd, 32'h00000000);
    bus_access(1'b0, 8'h0c, 8'h00, 4'hf);
    check(rd, 32'h00000000);
    bus_access(1'b0, 8'h14, 8'h00, 4'hf);
    check(rd, 32'h00000000);
    finish_test();
  end
endmodule

`default_nettype wire
